/* peripheral_reset_clock_gate.sv */
// peripheral reset lines and fast bus clock gates behind wishbone
// assumes synchronous active-low reset and a single 40 MHz clock
//
// Added by the designer: the Wishbone slave port.
`default_nettype none
module peripheral_reset_clock_gate (
   input wire logic SYS_CLK_I,
   input wire logic RST_B_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   output prcg_pkg::periph_resets_t PERIPH_RESETS_O,
   output prcg_pkg::clock_gates_t CLOCK_GATES_O
);
   logic [31:0] rst_ctrl_ff;
   logic [31:0] clk_gate_ff;
   logic req;
   logic hit_rst;
   logic hit_gate;
   logic [31:0] byte_mask;

   function automatic logic [31:0] lanes(input logic [3:0] sel);
      lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction : lanes

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [31:0] bm,
      input logic [31:0] rm);
      merge = ((old & ~bm) | (wd & bm)) & rm;
   endfunction : merge

   assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   assign hit_rst = WB_ADR_I == prcg_pkg::RST_CTRL_OFS;
   assign hit_gate = WB_ADR_I == prcg_pkg::CLK_GATE_OFS;
   assign byte_mask = lanes(WB_SEL_I);

   ////////////////////////////////////////////////////////////////////////
   // bus answer: one wait state, ack for one cycle, unmapped reads zero
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         WB_ACK_O <= 1'b0;
      end else begin
         WB_ACK_O <= req;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         WB_DAT_O <= 32'h0000_0000;
      end else if (req && !WB_WE_I) begin
         if (hit_rst) begin
            WB_DAT_O <= rst_ctrl_ff;
         end else if (hit_gate) begin
            WB_DAT_O <= clk_gate_ff;
         end else begin
            WB_DAT_O <= 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers; reserved bits are forced to zero
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         rst_ctrl_ff <= prcg_pkg::RST_CTRL_RESET;
      end else if (req && WB_WE_I && hit_rst) begin
         rst_ctrl_ff <= merge(rst_ctrl_ff, WB_DAT_I, byte_mask,
            prcg_pkg::RST_CTRL_MASK);
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         clk_gate_ff <= prcg_pkg::CLK_GATE_RESET;
      end else if (req && WB_WE_I && hit_gate) begin
         clk_gate_ff <= merge(clk_gate_ff, WB_DAT_I, byte_mask,
            prcg_pkg::CLK_GATE_MASK);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs, one cycle behind the register bits
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         PERIPH_RESETS_O <= '0;
      end else begin
         PERIPH_RESETS_O.comparator_reset <=
            rst_ctrl_ff[prcg_pkg::COMPARATOR_BIT];
         PERIPH_RESETS_O.basic_timer_reset <=
            rst_ctrl_ff[prcg_pkg::BASIC_TIMER_BIT];
         PERIPH_RESETS_O.general_timer_reset <=
            rst_ctrl_ff[prcg_pkg::GENERAL_TIMER_BIT];
         PERIPH_RESETS_O.advanced_timer_reset <=
            rst_ctrl_ff[prcg_pkg::ADVANCED_TIMER_BIT];
         PERIPH_RESETS_O.serial_periph_reset <=
            rst_ctrl_ff[prcg_pkg::SERIAL_PERIPH_BIT];
         PERIPH_RESETS_O.converter_reset <=
            rst_ctrl_ff[prcg_pkg::CONVERTER_BIT];
         PERIPH_RESETS_O.power_interface_reset <=
            rst_ctrl_ff[prcg_pkg::POWER_IF_BIT];
         PERIPH_RESETS_O.two_wire_reset <=
            rst_ctrl_ff[prcg_pkg::TWO_WIRE_BIT];
         PERIPH_RESETS_O.second_serial_port_reset <=
            rst_ctrl_ff[prcg_pkg::SECOND_SERIAL_BIT];
         PERIPH_RESETS_O.first_serial_port_reset <=
            rst_ctrl_ff[prcg_pkg::FIRST_SERIAL_BIT];
         PERIPH_RESETS_O.port_b_io_reset <=
            rst_ctrl_ff[prcg_pkg::PORT_B_BIT];
         PERIPH_RESETS_O.port_a_io_reset <=
            rst_ctrl_ff[prcg_pkg::PORT_A_BIT];
         PERIPH_RESETS_O.tone_generator_reset <=
            rst_ctrl_ff[prcg_pkg::TONE_BIT];
         PERIPH_RESETS_O.alt_function_reset <=
            rst_ctrl_ff[prcg_pkg::ALT_FUNC_BIT];
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         CLOCK_GATES_O <= '0;
      end else begin
         CLOCK_GATES_O.converter_clock_enable <=
            clk_gate_ff[prcg_pkg::CONVERTER_CLK_BIT];
         CLOCK_GATES_O.checksum_clock_enable <=
            clk_gate_ff[prcg_pkg::CHECKSUM_CLK_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_B_I);

   // bus handshake
   AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held two cycles");
   AST_ACK_FOLLOWS: assert property (req |=> WB_ACK_O)
      else $error("request not acked next cycle");
   AST_DAT_HOLD: assert property (!(req && !WB_WE_I) |=> $stable(WB_DAT_O))
      else $error("read data moved without a read");

   // register contents and read path
   AST_RST_RESERVED: assert property (
      (rst_ctrl_ff & ~prcg_pkg::RST_CTRL_MASK) == 32'h0000_0000)
      else $error("reserved reset bit set");
   AST_GATE_RESERVED: assert property (
      (clk_gate_ff & ~prcg_pkg::CLK_GATE_MASK) == 32'h0000_0000)
      else $error("reserved gate bit set");
   AST_RST_ECHO: assert property (
      req && !WB_WE_I && hit_rst |=> WB_DAT_O == $past(rst_ctrl_ff))
      else $error("reset register read wrong");
   AST_GATE_ECHO: assert property (
      req && !WB_WE_I && hit_gate |=> WB_DAT_O == $past(clk_gate_ff))
      else $error("gate register read wrong");
   AST_UNMAPPED_READ: assert property (
      req && !WB_WE_I && !hit_rst && !hit_gate |=>
      WB_DAT_O == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_UNMAPPED_WRITE: assert property (
      req && WB_WE_I && !hit_rst && !hit_gate |=>
      $stable(rst_ctrl_ff) && $stable(clk_gate_ff))
      else $error("unmapped write changed a register");

   // system reset clears everything, checked on the cycle after reset is sampled low
   AST_RESET_CLEARS: assert property (disable iff (1'b0)
      !RST_B_I |=> rst_ctrl_ff == 32'h0000_0000 &&
      clk_gate_ff == 32'h0000_0000 && PERIPH_RESETS_O == '0 &&
      CLOCK_GATES_O == '0 && !WB_ACK_O)
      else $error("reset left a bit set");

   // outputs follow their register bits one cycle later
   AST_PWR_FOLLOW: assert property (
      PERIPH_RESETS_O.power_interface_reset ==
      $past(rst_ctrl_ff[prcg_pkg::POWER_IF_BIT]))
      else $error("power reset not following bit");
   AST_PORTB_FOLLOW: assert property (
      PERIPH_RESETS_O.port_b_io_reset ==
      $past(rst_ctrl_ff[prcg_pkg::PORT_B_BIT]))
      else $error("port b reset not following bit");
   AST_PORTA_FOLLOW: assert property (
      PERIPH_RESETS_O.port_a_io_reset ==
      $past(rst_ctrl_ff[prcg_pkg::PORT_A_BIT]))
      else $error("port a reset not following bit");
   AST_AFIO_FOLLOW: assert property (
      PERIPH_RESETS_O.alt_function_reset ==
      $past(rst_ctrl_ff[prcg_pkg::ALT_FUNC_BIT]))
      else $error("alt function reset not following bit");
   AST_ALL_FOLLOW: assert property (
      PERIPH_RESETS_O == $past({rst_ctrl_ff[14:10], rst_ctrl_ff[8:0]}))
      else $error("reset lines not following bits");
   AST_RST_WRITE: assert property (
      req && WB_WE_I && hit_rst && WB_SEL_I[1] |=> ##1
      PERIPH_RESETS_O.comparator_reset ==
      $past(WB_DAT_I[prcg_pkg::COMPARATOR_BIT], 2))
      else $error("comparator reset not written");
   AST_ADC_GATE: assert property (
      req && WB_WE_I && hit_gate && WB_SEL_I[1] |=> ##1
      CLOCK_GATES_O.converter_clock_enable ==
      $past(WB_DAT_I[prcg_pkg::CONVERTER_CLK_BIT], 2))
      else $error("converter clock gate wrong");
   AST_CRC_GATE: assert property (
      CLOCK_GATES_O.checksum_clock_enable ==
      $past(clk_gate_ff[prcg_pkg::CHECKSUM_CLK_BIT]))
      else $error("checksum clock gate wrong");

   COV_RST_WRITE: cover property (req && WB_WE_I && hit_rst);
   COV_GATE_READ: cover property (req && !WB_WE_I && hit_gate);
   COV_UNMAPPED: cover property (req && !hit_rst && !hit_gate);
   COV_PWR_PULSE: cover property (PERIPH_RESETS_O.power_interface_reset
      ##[1:50] !PERIPH_RESETS_O.power_interface_reset);
   COV_BOTH_CLOCKS: cover property (CLOCK_GATES_O.converter_clock_enable
      && CLOCK_GATES_O.checksum_clock_enable);
endmodule : peripheral_reset_clock_gate
`default_nettype wire

/* prcg_pkg.sv */
// package for the peripheral reset and clock gate block
// assumes a 32-bit classic wishbone slave on one system clock
`default_nettype none
package prcg_pkg;
   localparam logic [7:0] RST_CTRL_OFS = 8'h0c;
   localparam logic [7:0] CLK_GATE_OFS = 8'h10;
   localparam logic [31:0] RST_CTRL_MASK = 32'h0000_7dff;
   localparam logic [31:0] CLK_GATE_MASK = 32'h0000_1040;
   localparam logic [31:0] RST_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CLK_GATE_RESET = 32'h0000_0000;
   localparam int COMPARATOR_BIT = 14;
   localparam int BASIC_TIMER_BIT = 13;
   localparam int GENERAL_TIMER_BIT = 12;
   localparam int ADVANCED_TIMER_BIT = 11;
   localparam int SERIAL_PERIPH_BIT = 10;
   localparam int CONVERTER_BIT = 8;
   localparam int POWER_IF_BIT = 7;
   localparam int TWO_WIRE_BIT = 6;
   localparam int SECOND_SERIAL_BIT = 5;
   localparam int FIRST_SERIAL_BIT = 4;
   localparam int PORT_B_BIT = 3;
   localparam int PORT_A_BIT = 2;
   localparam int TONE_BIT = 1;
   localparam int ALT_FUNC_BIT = 0;
   localparam int CONVERTER_CLK_BIT = 12;
   localparam int CHECKSUM_CLK_BIT = 6;

   typedef struct packed {
      logic comparator_reset;
      logic basic_timer_reset;
      logic general_timer_reset;
      logic advanced_timer_reset;
      logic serial_periph_reset;
      logic converter_reset;
      logic power_interface_reset;
      logic two_wire_reset;
      logic second_serial_port_reset;
      logic first_serial_port_reset;
      logic port_b_io_reset;
      logic port_a_io_reset;
      logic tone_generator_reset;
      logic alt_function_reset;
   } periph_resets_t;

   typedef struct packed {
      logic converter_clock_enable;
      logic checksum_clock_enable;
   } clock_gates_t;
endpackage : prcg_pkg
`default_nettype wire

/* testbench.sv */
// self-checking bench for the peripheral reset and clock gate block
// assumes prcg_pkg and the design are compiled first
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic SYS_CLK_I = 1'b0;
   logic RST_B_I = 1'b0;
   logic WB_CYC_I = 1'b0;
   logic WB_STB_I = 1'b0;
   logic WB_WE_I = 1'b0;
   logic [7:0] WB_ADR_I = 8'h00;
   logic [3:0] WB_SEL_I = 4'h0;
   logic [31:0] WB_DAT_I = 32'h0000_0000;
   logic [31:0] WB_DAT_O;
   logic WB_ACK_O;
   prcg_pkg::periph_resets_t PERIPH_RESETS_O;
   prcg_pkg::clock_gates_t CLOCK_GATES_O;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [31:0] rst_m;
   logic [31:0] gate_m;
   ////////////////////////////////////////////////////////////////////////
   peripheral_reset_clock_gate DUT (
      .SYS_CLK_I(SYS_CLK_I),
      .RST_B_I(RST_B_I),
      .WB_CYC_I(WB_CYC_I),
      .WB_STB_I(WB_STB_I),
      .WB_WE_I(WB_WE_I),
      .WB_ADR_I(WB_ADR_I),
      .WB_SEL_I(WB_SEL_I),
      .WB_DAT_I(WB_DAT_I),
      .WB_DAT_O(WB_DAT_O),
      .WB_ACK_O(WB_ACK_O),
      .PERIPH_RESETS_O(PERIPH_RESETS_O),
      .CLOCK_GATES_O(CLOCK_GATES_O)
   );
   always #12.5 SYS_CLK_I = ~SYS_CLK_I;
   always @(posedge SYS_CLK_I) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      if (n_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one classic cycle; held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [3:0] sel, input logic [31:0] dat,
                     output logic [31:0] q);
      @(posedge SYS_CLK_I);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I <= we;
      WB_ADR_I <= adr;
      WB_SEL_I <= sel;
      WB_DAT_I <= dat;
      do @(posedge SYS_CLK_I); while (WB_ACK_O !== 1'b1);
      q = WB_DAT_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
      WB_WE_I <= 1'b0;
   endtask : wb
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction : merge
   task automatic wr(input logic [7:0] adr, input logic [3:0] sel,
                     input logic [31:0] dat);
      logic [31:0] q;
      wb(1'b1, adr, sel, dat, q);
      if (adr == prcg_pkg::RST_CTRL_OFS)
         rst_m = merge(rst_m, dat, sel) & prcg_pkg::RST_CTRL_MASK;
      if (adr == prcg_pkg::CLK_GATE_OFS)
         gate_m = merge(gate_m, dat, sel) & prcg_pkg::CLK_GATE_MASK;
   endtask : wr
   // reads ignore the byte enables, so they are drawn at random
   task automatic check_all;
      logic [31:0] q;
      logic [31:0] e;
      logic [31:0] r;
      wb(1'b0, prcg_pkg::RST_CTRL_OFS, 4'($urandom), 32'h0000_0000, q);
      check("reset reg", q, rst_m);
      wb(1'b0, prcg_pkg::CLK_GATE_OFS, 4'($urandom), 32'h0000_0000, q);
      check("gate reg", q, gate_m);
      e = {18'h0, rst_m[14:10], rst_m[8:0]};
      r = 32'(PERIPH_RESETS_O);
      check("resets", r, e);
      check("io resets", r & 32'h8d, e & 32'h8d);
      e = {30'h0, gate_m[12], gate_m[6]};
      check("gates", 32'(CLOCK_GATES_O), e);
   endtask : check_all
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] q;
      logic [31:0] d;
      logic [7:0] a;
      rst_m = 32'h0000_0000;
      gate_m = 32'h0000_0000;
      void'($urandom(34796));
      repeat (5) @(posedge SYS_CLK_I);
      RST_B_I <= 1'b1;
      check_all();
      // walk a single one through every implemented bit of both registers
      for (int i = 0; i < 33; i++) begin
         d = (i < 32) ? 32'h1 << i : 32'h0;
         wr(prcg_pkg::RST_CTRL_OFS, 4'hf,
            d & prcg_pkg::RST_CTRL_MASK);
         wr(prcg_pkg::CLK_GATE_OFS, 4'hf,
            d & prcg_pkg::CLK_GATE_MASK);
         check_all();
      end
      for (int i = 0; i < 300; i++) begin
         case ($urandom_range(2))
            0: a = prcg_pkg::RST_CTRL_OFS;
            1: a = prcg_pkg::CLK_GATE_OFS;
            default: a = 8'($urandom);
         endcase
         d = $urandom;
         if (a == prcg_pkg::RST_CTRL_OFS) begin
            d &= prcg_pkg::RST_CTRL_MASK;
         end
         if (a == prcg_pkg::CLK_GATE_OFS) begin
            d &= prcg_pkg::CLK_GATE_MASK;
         end
         wr(a, 4'($urandom), d);
         if (a != prcg_pkg::RST_CTRL_OFS && a != prcg_pkg::CLK_GATE_OFS) begin
            wb(1'b0, a, 4'hf, 32'h0000_0000, q);
            check("unmapped", q, 32'h0000_0000);
         end
         check_all();
      end
      // everything set, then a reset in mid-run
      wr(prcg_pkg::RST_CTRL_OFS, 4'hf, prcg_pkg::RST_CTRL_MASK);
      wr(prcg_pkg::CLK_GATE_OFS, 4'hf, prcg_pkg::CLK_GATE_MASK);
      check_all();
      RST_B_I <= 1'b0;
      repeat (3) @(posedge SYS_CLK_I);
      RST_B_I <= 1'b1;
      rst_m = 32'h0000_0000;
      gate_m = 32'h0000_0000;
      check_all();
      stop_test();
   end
endmodule : testbench
`default_nettype wire
